/* File: tsio_pkg.sv */
package tsio_pkg;

  // --------------------------------------------------------------------------
  // Port geometry
  // --------------------------------------------------------------------------
  localparam int NUM_LINES = 7;
  localparam int NUM_KEYS  = 6;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_KEY_COUNT      = 8'h01;
  localparam logic [7:0] ADDR_DETECT_STATUS  = 8'h02;
  localparam logic [7:0] ADDR_INPUT_STATUS   = 8'h03;
  localparam logic [7:0] ADDR_KEY_ENABLED    = 8'h04;
  localparam logic [7:0] ADDR_DIRECTION_MASK = 8'h17;
  localparam logic [7:0] ADDR_PWM_SELECT     = 8'h18;
  localparam logic [7:0] ADDR_DETECT_LINK    = 8'h19;
  localparam logic [7:0] ADDR_POLARITY       = 8'h1A;
  localparam logic [7:0] ADDR_USER_OUTPUT    = 8'h1B;
  localparam logic [7:0] ADDR_PWM_LEVEL      = 8'h1C;

  // --------------------------------------------------------------------------
  // Reset values, standalone direction and unmapped read value
  // --------------------------------------------------------------------------
  localparam logic [6:0] RST_DIRECTION       = 7'h00;
  localparam logic [6:0] STANDALONE_DIR      = 7'h7F;
  localparam logic [6:0] RST_PWM_SELECT      = 7'h00;
  localparam logic [6:0] RST_DETECT_LINK     = 7'h3F;
  localparam logic [6:0] RST_POLARITY        = 7'h00;
  localparam logic [6:0] RST_USER_OUTPUT     = 7'h00;
  localparam logic [7:0] RST_PWM_LEVEL       = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE        = 2'h3;
  localparam int         BURST_CNT_W         = 16;
  localparam logic [3:0] I2C_BITS            = 4'h8;

  typedef enum logic [6:0] {
    I2C_IDLE  = 7'h01,
    I2C_ADDR  = 7'h02,
    I2C_ACK_A = 7'h04,
    I2C_WRITE = 7'h08,
    I2C_ACK_W = 7'h10,
    I2C_READ  = 7'h20,
    I2C_ACK_R = 7'h40
  } tsio_i2c_state_e;

endpackage : tsio_pkg

/* File: tsio_i2c_slave.sv */
`timescale 1ns/1ps
module tsio_i2c_slave
  import tsio_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h12
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_rd_data,
  output logic            o_sda_oe,
  output logic [7:0]      o_ptr,
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_stb,
  output logic [7:0]      o_rd_addr
);

  typedef struct packed {
    logic            scl_d;
    logic            sda_d;
    tsio_i2c_state_e st;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      tx;
    logic            rw;
    logic            first;
    logic            nack;
    logic [7:0]      ptr;
    logic            sda_oe;
    logic            wr_stb;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_data;
    logic            rd_stb;
    logic [7:0]      rd_addr;
  } tsio_i2c_s;

  tsio_i2c_s r, nxt;

  logic scl_rise, scl_fall, start_c, stop_c;

  // --------------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------------
  always_comb begin
    scl_rise = i_scl & ~r.scl_d;
    scl_fall = ~i_scl & r.scl_d;
    start_c  = i_scl & r.scl_d & r.sda_d & ~i_sda;
    stop_c   = i_scl & r.scl_d & ~r.sda_d & i_sda;
    nxt        = r;
    nxt.scl_d  = i_scl;
    nxt.sda_d  = i_sda;
    nxt.wr_stb = 1'b0;
    nxt.rd_stb = 1'b0;
    if (!i_enable || stop_c) begin
      nxt.st     = I2C_IDLE;
      nxt.sda_oe = 1'b0;
    end else if (start_c) begin
      // Repeated start keeps the register pointer
      nxt.st     = I2C_ADDR;
      nxt.cnt    = 4'h0;
      nxt.sda_oe = 1'b0;
    end else begin
      case (r.st)
        I2C_IDLE: begin
        end
        I2C_ADDR, I2C_WRITE: begin
          if (scl_rise) begin
            nxt.sh  = {r.sh[6:0], i_sda};
            nxt.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == I2C_BITS) begin
            nxt.cnt = 4'h0;
            if (r.st == I2C_ADDR) begin
              if (r.sh[7:1] == DEV_ADDR) begin
                nxt.st     = I2C_ACK_A;
                nxt.sda_oe = 1'b1;
                nxt.rw     = r.sh[0];
                nxt.first  = 1'b1;
              end else begin
                nxt.st = I2C_IDLE;
              end
            end else begin
              nxt.st     = I2C_ACK_W;
              nxt.sda_oe = 1'b1;
              nxt.first  = 1'b0;
              if (r.first) begin
                nxt.ptr = r.sh;
              end else begin
                nxt.wr_stb  = 1'b1;
                nxt.wr_addr = r.ptr;
                nxt.wr_data = r.sh;
                nxt.ptr     = r.ptr + 8'h01;
              end
            end
          end
        end
        I2C_ACK_W: begin
          if (scl_fall) begin
            nxt.st     = I2C_WRITE;
            nxt.sda_oe = 1'b0;
          end
        end
        I2C_ACK_A, I2C_ACK_R: begin
          if (scl_rise) begin
            nxt.nack = i_sda;
          end else if (scl_fall) begin
            if (r.st == I2C_ACK_A && !r.rw) begin
              nxt.st     = I2C_WRITE;
              nxt.sda_oe = 1'b0;
            end else if (r.st == I2C_ACK_R && r.nack) begin
              nxt.st     = I2C_IDLE;
              nxt.sda_oe = 1'b0;
            end else begin
              nxt.st      = I2C_READ;
              nxt.cnt     = 4'h0;
              nxt.tx      = i_rd_data;
              nxt.sda_oe  = ~i_rd_data[7];
              nxt.rd_stb  = 1'b1;
              nxt.rd_addr = r.ptr;
              nxt.ptr     = r.ptr + 8'h01;
            end
          end
        end
        I2C_READ: begin
          if (scl_fall) begin
            nxt.cnt = r.cnt + 4'h1;
            if (r.cnt == I2C_BITS - 4'h1) begin
              nxt.st     = I2C_ACK_R;
              nxt.sda_oe = 1'b0;
            end else begin
              nxt.tx     = {r.tx[6:0], 1'b0};
              nxt.sda_oe = ~r.tx[6];
            end
          end
        end
        default: begin
          nxt.st     = I2C_IDLE;
          nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r       <= '0;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.st    <= I2C_IDLE;
    end else begin
      r <= nxt;
    end
  end

  assign o_sda_oe  = r.sda_oe;
  assign o_ptr     = r.ptr;
  assign o_wr_stb  = r.wr_stb;
  assign o_wr_addr = r.wr_addr;
  assign o_wr_data = r.wr_data;
  assign o_rd_stb  = r.rd_stb;
  assign o_rd_addr = r.rd_addr;

endmodule : tsio_i2c_slave

/* File: tsio_port_top.sv */
// Summary of operation
// - Seven lines, each input or output
// - One shared 256-step PWM level
// - Lines start as inputs unless standalone
// - SDA low, SCL high at power-up: standalone
// - Standalone forces all seven lines to outputs
// - Direction one is output, zero input
// - Input status shows input line levels
// - Input level change asserts change line
// - Open-drain change line, released by input status read
// - PWM mask selects PWM or digital drive
// - PWM duty register writable over I2C
// - Detect mask links line to key detection
// - Polarity mask one high, zero low
// - Two to six keys; absent capacitor disables
// - Burst sequence skips disabled keys
`timescale 1ns/1ps
module tsio_port_top
  import tsio_pkg::*;
#(
  parameter logic [6:0]             DEV_ADDR     = 7'h12,
  parameter logic [BURST_CNT_W-1:0] BURST_CYCLES = 16'h0010
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST,
  input  wire logic [NUM_LINES-1:0] I_PORT_LINE,
  output logic      [NUM_LINES-1:0] O_PORT_LINE,
  output logic      [NUM_LINES-1:0] O_PORT_LINE_OE,
  input  wire logic                 I_SCL,
  input  wire logic                 I_SDA,
  output logic                      O_SDA,
  output logic                      O_SDA_OE,
  output logic                      O_CHANGE_NOTIFY_N,
  output logic                      O_CHANGE_NOTIFY_N_OE,
  input  wire logic [NUM_KEYS-1:0]  I_KEY_DETECT,
  input  wire logic [NUM_KEYS-1:0]  I_KEY_CAP_OK,
  output logic      [2:0]           O_BURST_KEY,
  output logic                      O_BURST_START,
  output logic                      O_STANDALONE
);

  typedef struct packed {
    logic [NUM_LINES-1:0]   lin_m;
    logic [NUM_LINES-1:0]   lin_s;
    logic                   sda_m;
    logic                   sda_s;
    logic                   scl_m;
    logic                   scl_s;
    logic [1:0]             strap_cnt;
    logic                   strap_done;
    logic                   standalone;
    logic [NUM_LINES-1:0]   dir;
    logic [NUM_LINES-1:0]   pwm_sel;
    logic [NUM_LINES-1:0]   det_link;
    logic [NUM_LINES-1:0]   pol;
    logic [NUM_LINES-1:0]   user_buf;
    logic [7:0]             pwm_level;
    logic [7:0]             pwm_cnt;
    logic [NUM_LINES-1:0]   in_prev;
    logic [NUM_LINES-1:0]   dir_prev;
    logic [NUM_KEYS-1:0]    det_prev;
    logic                   notify;
    logic [NUM_LINES-1:0]   pin_out;
    logic [NUM_LINES-1:0]   pin_oe;
    logic [2:0]             burst_key;
    logic                   burst_start;
    logic [BURST_CNT_W-1:0] burst_cnt;
  } tsio_top_s;

  tsio_top_s r, nxt;

  logic                 sda_oe_i;
  logic [7:0]           ptr_i;
  logic                 wr_stb_i;
  logic [7:0]           wr_addr_i;
  logic [7:0]           wr_data_i;
  logic                 rd_stb_i;
  logic [7:0]           rd_addr_i;
  logic [7:0]           rd_data;
  logic [NUM_KEYS-1:0]  key_en;
  logic [NUM_KEYS-1:0]  det_now;
  logic [NUM_LINES-1:0] det_line;
  logic [NUM_LINES-1:0] in_lvl;
  logic [NUM_LINES-1:0] act;
  logic [NUM_LINES-1:0] lvl;
  logic                 pwm_on;
  logic [NUM_LINES-1:0] in_delta;
  logic                 det_delta;
  logic                 notify_set;
  logic                 notify_clr;
  logic                 reg_wr;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] key_count(input logic [NUM_KEYS-1:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < NUM_KEYS; i++) begin
      c = c + {7'h00, m[i]};
    end
    return c;
  endfunction : key_count

  // Next enabled key after cur, wrapping; cur itself if it is the only one
  function automatic logic [2:0] next_key(input logic [2:0] cur, input logic [NUM_KEYS-1:0] m);
    logic [2:0] k;
    logic [2:0] res;
    logic       hit;
    k   = cur;
    res = cur;
    hit = 1'b0;
    for (int i = 0; i < NUM_KEYS; i++) begin
      k = (k == 3'(NUM_KEYS - 1)) ? 3'h0 : k + 3'h1;
      if (!hit && m[k]) begin
        res = k;
        hit = 1'b1;
      end
    end
    return res;
  endfunction : next_key

  // Active state gated by PWM, then mapped onto the pin's polarity
  function automatic logic [NUM_LINES-1:0] pin_level(input logic [NUM_LINES-1:0] act_m,
                                                    input logic [NUM_LINES-1:0] pwm_m,
                                                    input logic                 pwm_hi,
                                                    input logic [NUM_LINES-1:0] pol_m);
    logic [NUM_LINES-1:0] gated;
    gated = act_m & (~pwm_m | {NUM_LINES{pwm_hi}});
    return (pol_m & gated) | (~pol_m & ~gated);
  endfunction : pin_level

  // --------------------------------------------------------------------------
  // Serial slave
  // --------------------------------------------------------------------------
  tsio_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_enable  (r.strap_done & ~r.standalone),
    .i_scl     (r.scl_s),
    .i_sda     (r.sda_s),
    .i_rd_data (rd_data),
    .o_sda_oe  (sda_oe_i),
    .o_ptr     (ptr_i),
    .o_wr_stb  (wr_stb_i),
    .o_wr_addr (wr_addr_i),
    .o_wr_data (wr_data_i),
    .o_rd_stb  (rd_stb_i),
    .o_rd_addr (rd_addr_i)
  );

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb begin
    case (ptr_i)
      ADDR_KEY_COUNT:      rd_data = key_count(key_en);
      ADDR_DETECT_STATUS:  rd_data = {2'b00, det_now};
      ADDR_INPUT_STATUS:   rd_data = {1'b0, in_lvl};
      ADDR_KEY_ENABLED:    rd_data = {2'b00, key_en};
      ADDR_DIRECTION_MASK: rd_data = {1'b0, r.dir};
      ADDR_PWM_SELECT:     rd_data = {1'b0, r.pwm_sel};
      ADDR_DETECT_LINK:    rd_data = {1'b0, r.det_link};
      ADDR_POLARITY:       rd_data = {1'b0, r.pol};
      ADDR_USER_OUTPUT:    rd_data = {1'b0, r.user_buf};
      ADDR_PWM_LEVEL:      rd_data = r.pwm_level;
      default:             rd_data = UNMAPPED_READ;
    endcase
  end

  // --------------------------------------------------------------------------
  // Port logic
  // --------------------------------------------------------------------------
  always_comb begin
    key_en   = I_KEY_CAP_OK;
    det_now  = I_KEY_DETECT & key_en;
    // Line 6 has no sense channel, so it never shows a detection
    det_line = {1'b0, det_now};
    in_lvl   = r.lin_s & ~r.dir;
    pwm_on   = r.pwm_cnt < r.pwm_level;
    act      = (r.det_link & det_line) | (~r.det_link & r.user_buf);
    lvl      = pin_level(act, r.pwm_sel, pwm_on, r.pol);
    reg_wr   = wr_stb_i & ~r.standalone;

    // ------------------------------------------------------
    // Change line
    // ------------------------------------------------------
    // Lines that were outputs last cycle are skipped, so a direction write is no event
    in_delta   = (in_lvl ^ r.in_prev) & ~r.dir & ~r.dir_prev;
    det_delta  = det_now != r.det_prev;
    notify_set = r.strap_done & ((|in_delta) | det_delta);
    // Only the input status read releases the line, the last of the two status bytes
    notify_clr = rd_stb_i && (rd_addr_i == ADDR_INPUT_STATUS);

    // ------------------------------------------------------
    // Synchronisers and free-running counter
    // ------------------------------------------------------
    nxt          = r;
    nxt.lin_m    = I_PORT_LINE;
    nxt.lin_s    = r.lin_m;
    nxt.sda_m    = I_SDA;
    nxt.sda_s    = r.sda_m;
    nxt.scl_m    = I_SCL;
    nxt.scl_s    = r.scl_m;
    nxt.pwm_cnt  = r.pwm_cnt + 8'h01;
    nxt.in_prev  = in_lvl;
    nxt.dir_prev = r.dir;
    nxt.det_prev = det_now;
    // An event in the clearing cycle wins, so no change is lost
    nxt.notify   = notify_set | (r.notify & ~notify_clr);

    // ------------------------------------------------------
    // Strap sampling
    // ------------------------------------------------------
    // Straps are sampled once the synchronisers have filled after reset
    if (!r.strap_done) begin
      nxt.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == STRAP_SETTLE) begin
        nxt.strap_done = 1'b1;
        nxt.standalone = ~r.sda_s & r.scl_s;
        if (~r.sda_s & r.scl_s) begin
          nxt.dir = STANDALONE_DIR;
        end
      end
    end

    // ------------------------------------------------------
    // Register writes
    // ------------------------------------------------------
    if (reg_wr) begin
      case (wr_addr_i)
        ADDR_DIRECTION_MASK: nxt.dir       = wr_data_i[NUM_LINES-1:0];
        ADDR_PWM_SELECT:     nxt.pwm_sel   = wr_data_i[NUM_LINES-1:0];
        ADDR_DETECT_LINK:    nxt.det_link  = wr_data_i[NUM_LINES-1:0];
        ADDR_POLARITY:       nxt.pol       = wr_data_i[NUM_LINES-1:0];
        ADDR_USER_OUTPUT:    nxt.user_buf  = wr_data_i[NUM_LINES-1:0];
        ADDR_PWM_LEVEL:      nxt.pwm_level = wr_data_i;
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------
    nxt.pin_out = lvl;
    // Enable trails the mask by one cycle, in step with the level
    nxt.pin_oe  = r.dir;

    // ------------------------------------------------------
    // Burst slots
    // ------------------------------------------------------
    // Disabled keys never get a burst slot, shortening the cycle
    nxt.burst_start = 1'b0;
    if (r.burst_cnt >= BURST_CYCLES - 1'b1) begin
      nxt.burst_cnt = '0;
      if (|key_en) begin
        nxt.burst_key   = next_key(r.burst_key, key_en);
        nxt.burst_start = 1'b1;
      end
    end else begin
      nxt.burst_cnt = r.burst_cnt + 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      r           <= '0;
      // Pin synchronisers idle high; change detection waits for strap sampling
      r.lin_m     <= '1;
      r.lin_s     <= '1;
      r.in_prev   <= '0;
      r.sda_m     <= 1'b1;
      r.sda_s     <= 1'b1;
      r.scl_m     <= 1'b1;
      r.scl_s     <= 1'b1;
      r.dir       <= RST_DIRECTION;
      r.pwm_sel   <= RST_PWM_SELECT;
      r.det_link  <= RST_DETECT_LINK;
      r.pol       <= RST_POLARITY;
      r.user_buf  <= RST_USER_OUTPUT;
      r.pwm_level <= RST_PWM_LEVEL;
      r.burst_key <= 3'(NUM_KEYS - 1);
    end else begin
      r <= nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_PORT_LINE          = r.pin_out;
  assign O_PORT_LINE_OE       = r.pin_oe;
  // Open-drain pins only ever pull low; the enables carry the level
  assign O_SDA                = 1'b0;
  assign O_SDA_OE             = sda_oe_i;
  assign O_CHANGE_NOTIFY_N    = 1'b0;
  assign O_CHANGE_NOTIFY_N_OE = r.notify;
  assign O_BURST_KEY          = r.burst_key;
  assign O_BURST_START        = r.burst_start;
  assign O_STANDALONE         = r.standalone;

endmodule : tsio_port_top

/* File: tsio_port_top_properties.sv */
`timescale 1ns/1ps
module tsio_port_top_properties
  import tsio_pkg::*;
#(
  parameter logic [6:0]             DEV_ADDR     = 7'h12,
  parameter logic [BURST_CNT_W-1:0] BURST_CYCLES = 16'h0010
) (
  input wire logic                 I_CLK,
  input wire logic                 I_RST,
  input wire logic [NUM_LINES-1:0] I_PORT_LINE,
  input wire logic [NUM_LINES-1:0] O_PORT_LINE,
  input wire logic [NUM_LINES-1:0] O_PORT_LINE_OE,
  input wire logic                 I_SCL,
  input wire logic                 I_SDA,
  input wire logic                 O_SDA_OE,
  input wire logic                 O_CHANGE_NOTIFY_N,
  input wire logic                 O_CHANGE_NOTIFY_N_OE,
  input wire logic [NUM_KEYS-1:0]  I_KEY_DETECT,
  input wire logic [NUM_KEYS-1:0]  I_KEY_CAP_OK,
  input wire logic [2:0]           O_BURST_KEY,
  input wire logic                 O_BURST_START,
  input wire logic                 O_STANDALONE
);
  logic [3:0] since_rst_r;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // Strap sampling keeps change detection off for the first cycles
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      since_rst_r <= 4'h0;
    end else if (since_rst_r != 4'hF) begin
      since_rst_r <= since_rst_r + 4'h1;
    end
  end

  sequence input_edge;
    since_rst_r == 4'hF && $changed(I_PORT_LINE & ~O_PORT_LINE_OE) && $stable(O_PORT_LINE_OE)
      ##1 $stable(O_PORT_LINE_OE) [*3];
  endsequence

  AST_RST_INPUTS: assert property ($fell(I_RST) |-> (O_PORT_LINE_OE == 7'h00) [*3])
    else $error("Port lines driven right after reset");
  AST_STRAP_LEVELS: assert property ($rose(O_STANDALONE) |-> !I_SDA && I_SCL)
    else $error("Standalone entered without strap levels");
  AST_STANDALONE_DIR: assert property ($past(O_STANDALONE, 3) |-> O_PORT_LINE_OE == 7'h7F)
    else $error("Standalone lines not all outputs");
  AST_STANDALONE_QUIET: assert property (O_STANDALONE |-> !O_SDA_OE)
    else $error("Serial port answered in standalone");
  AST_STANDALONE_PINS: assert property ((O_STANDALONE && O_PORT_LINE_OE == 7'h7F && $stable(I_KEY_DETECT)
    && $stable(I_KEY_CAP_OK)) [*3] |-> O_PORT_LINE == {1'b1, ~(I_KEY_DETECT & I_KEY_CAP_OK)})
    else $error("Detection not shown active low on port");
  AST_CHANGE_SET: assert property (input_edge |-> ##[0:5] O_CHANGE_NOTIFY_N_OE)
    else $error("Input change not flagged");
  AST_CHANGE_OPEN_DRAIN: assert property (O_CHANGE_NOTIFY_N == 1'b0)
    else $error("Change line drives high");
  AST_BURST_ENABLED: assert property (O_BURST_START && $stable(I_KEY_CAP_OK) |-> I_KEY_CAP_OK[O_BURST_KEY])
    else $error("Burst slot given to disabled key");
  AST_BURST_IDLE: assert property ((I_KEY_CAP_OK == 6'h00) [*3] |-> !O_BURST_START)
    else $error("Burst started with no key enabled");

  COV_CHANGE: cover property ($rose(O_CHANGE_NOTIFY_N_OE));
  COV_STANDALONE: cover property ($rose(O_STANDALONE));
  COV_ACK: cover property ($rose(O_SDA_OE));
  COV_BURST: cover property (O_BURST_START && O_BURST_KEY == 3'h5);
endmodule : tsio_port_top_properties

bind tsio_port_top tsio_port_top_properties #(.DEV_ADDR(DEV_ADDR), .BURST_CYCLES(BURST_CYCLES)) i_props (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_PORT_LINE(I_PORT_LINE), .O_PORT_LINE(O_PORT_LINE),
  .O_PORT_LINE_OE(O_PORT_LINE_OE), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_OE(O_SDA_OE),
  .O_CHANGE_NOTIFY_N(O_CHANGE_NOTIFY_N), .O_CHANGE_NOTIFY_N_OE(O_CHANGE_NOTIFY_N_OE),
  .I_KEY_DETECT(I_KEY_DETECT), .I_KEY_CAP_OK(I_KEY_CAP_OK), .O_BURST_KEY(O_BURST_KEY),
  .O_BURST_START(O_BURST_START), .O_STANDALONE(O_STANDALONE));

/* File: tsio_host_model.sv */
`timescale 1ns/1ps
module tsio_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h12,
  parameter int         HALF     = 10
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // Open drain: a one releases the line to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick();
    repeat (HALF) @(negedge i_clk);
  endtask : tick

  // SDA only moves half a phase after SCL falls, so no edge is read as START or STOP
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    o_scl = 1'b0;
    tick();
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] q, output logic s);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, s);
  endtask : byte_io

  task automatic start_cond();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
    tick();
  endtask : start_cond

  task automatic xact(input logic [7:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q,
                      output logic ok);
    logic [3:0] nak;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, nak[0]);
    byte_io(a, 1'b1, q, nak[1]);
    if (rd) begin
      start_cond();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, q, nak[2]);
      byte_io(8'hFF, 1'b1, q, nak[3]);
    end else begin
      byte_io(d, 1'b1, q, nak[2]);
    end
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
    tick();
    ok = (nak[2:0] === 3'b000);
  endtask : xact
endmodule : tsio_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import tsio_pkg::*;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [6:0] ext = 7'h00;
  logic [5:0] key_det = 6'h00;
  logic [5:0] cap_ok = 6'h00;
  logic       strap_low = 1'b0;
  logic       host_scl, host_sda, sda_oe, notify_oe, standalone, ok;
  logic [6:0] port_out, port_oe, pin;
  logic [7:0] q;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cnt;
  logic [7:0] lvl [3] = '{8'h40, 8'hFF, 8'h00};

  always #4 clk = ~clk;
  assign pin = (port_oe & port_out) | (~port_oe & ext);

  tsio_host_model #(.DEV_ADDR(7'h12)) i_tsio_host_model (
    .i_clk(clk), .i_sda(host_sda & ~sda_oe & ~strap_low), .o_scl(host_scl), .o_sda(host_sda));

  tsio_port_top #(.DEV_ADDR(7'h12), .BURST_CYCLES(16'h0010)) i_tsio_port_top (
    .I_CLK(clk), .I_RST(rst), .I_PORT_LINE(pin), .O_PORT_LINE(port_out), .O_PORT_LINE_OE(port_oe),
    .I_SCL(host_scl), .I_SDA(host_sda & ~sda_oe & ~strap_low), .O_SDA(), .O_SDA_OE(sda_oe),
    .O_CHANGE_NOTIFY_N(), .O_CHANGE_NOTIFY_N_OE(notify_oe), .I_KEY_DETECT(key_det),
    .I_KEY_CAP_OK(cap_ok), .O_BURST_KEY(), .O_BURST_START(), .O_STANDALONE(standalone));

  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_tests++;
    if (act !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : check

  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_tsio_host_model.xact(a, d, 1'b0, q, ok);
    check({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_tsio_host_model.xact(a, 8'h00, 1'b1, q, ok);
    check({7'h00, ok}, 8'h01);
    check(q, exp);
  endtask : rd

  task automatic do_reset(input logic s);
    strap_low = s;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
    strap_low = 1'b0;
  endtask : do_reset

  initial begin
    do_reset(1'b0);
    check({1'b0, port_oe}, 8'h00);
    check({7'h00, standalone}, 8'h00);
    rd(ADDR_DIRECTION_MASK, 8'h00);
    rd(ADDR_PWM_SELECT, {1'b0, RST_PWM_SELECT});
    rd(ADDR_DETECT_LINK, {1'b0, RST_DETECT_LINK});
    rd(ADDR_POLARITY, {1'b0, RST_POLARITY});
    rd(ADDR_PWM_LEVEL, RST_PWM_LEVEL);
    rd(8'h30, UNMAPPED_READ);
    wr(ADDR_DIRECTION_MASK, 8'h85);
    rd(ADDR_DIRECTION_MASK, 8'h05);
    check({1'b0, port_oe}, 8'h05);
    rd(ADDR_INPUT_STATUS, 8'h00);
    check({7'h00, notify_oe}, 8'h00);
    ext = 7'h5A;
    cnt = 0;
    while (notify_oe !== 1'b1 && cnt < 20) begin
      @(negedge clk);
      cnt++;
    end
    check({7'h00, notify_oe}, 8'h01);
    if (cnt >= 20) test_done();
    rd(ADDR_INPUT_STATUS, 8'h5A & ~8'h05);
    check({7'h00, notify_oe}, 8'h00);
    wr(ADDR_DETECT_LINK, 8'h00);
    wr(ADDR_POLARITY, 8'h03);
    wr(ADDR_USER_OUTPUT, 8'h0F);
    wr(ADDR_DIRECTION_MASK, 8'h7F);
    check({1'b0, port_out}, ~(8'h0F ^ 8'h03) & 8'h7F);
    cap_ok = 6'h3B;
    key_det = 6'h2D;
    wr(ADDR_DETECT_LINK, 8'h3F);
    wr(ADDR_POLARITY, 8'h7F);
    check({1'b0, port_out}, 8'h2D & 8'h3B);
    rd(ADDR_KEY_COUNT, 8'h05);
    rd(ADDR_KEY_ENABLED, 8'h3B);
    rd(ADDR_DETECT_STATUS, 8'h29);
    wr(ADDR_DETECT_LINK, 8'h00);
    wr(ADDR_USER_OUTPUT, 8'h01);
    wr(ADDR_PWM_SELECT, 8'h01);
    // Free-running counter: any 256 consecutive cycles hold exactly level high cycles
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_PWM_LEVEL, lvl[i]);
      cnt = 0;
      repeat (256) begin
        @(negedge clk);
        cnt += int'(port_out[0] === 1'b1);
      end
      check(cnt[7:0], lvl[i]);
    end
    wr(ADDR_PWM_SELECT, 8'h00);
    check({7'h00, port_out[0]}, 8'h01);
    cap_ok = 6'h3F;
    do_reset(1'b1);
    check({7'h00, standalone}, 8'h01);
    check({1'b0, port_oe}, 8'h7F);
    check({1'b0, port_out}, {2'b01, ~6'h2D});
    i_tsio_host_model.xact(ADDR_DIRECTION_MASK, 8'h00, 1'b0, q, ok);
    check({7'h00, ok}, 8'h00);
    check({1'b0, port_oe}, 8'h7F);
    test_done();
  end
endmodule : testbench
